// ===== hdl/usrx_rx_ctrl.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module usrx_rx_ctrl (
   // APB slave
   input  logic        pclk,
   input  logic        presetn,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [7:0]  paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // Serial link
   input  logic        rx_clk,
   input  logic        rx_data,
   // Transmitter state, same clock
   input  logic        tx_enable,
   // Interrupt
   output logic        irq
);
   logic        rxen_q;
   logic        rxen_d;
   logic        strip_q;
   logic        auto_q;
   logic [7:0]  sync_q;
   logic [3:0]  mask_q;
   logic [3:0]  stat_q;
   logic [3:0]  stat_d;
   logic [7:0]  buf_q;
   logic        full_q;
   logic        full_d;
   logic        ovr_pend_q;
   logic        brk_pend_q;
   logic        tx_prev_q;
   logic        sclk_p_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        irq_q;
   logic        rd_full_q;
   logic [1:0]  sync_o;
   logic [7:0]  word;
   logic        wv;
   logic        brk;

   // Bus decode
   wire pready_d  = psel & penable & ~pready_q;
   wire acc       = psel & penable & pready_q;
   wire wr        = acc & pwrite;
   wire rd        = acc & ~pwrite;
   wire hit_ctrl  = (paddr == usrx_pkg::ADDR_CTRL);
   wire hit_sync  = (paddr == usrx_pkg::ADDR_SYNC);
   wire hit_data  = (paddr == usrx_pkg::ADDR_DATA);
   wire hit_stat  = (paddr == usrx_pkg::ADDR_STAT);
   wire hit_mask  = (paddr == usrx_pkg::ADDR_MASK);
   wire hit_any   = hit_ctrl | hit_sync | hit_data | hit_stat | hit_mask;
   wire wr_ctrl   = wr & hit_ctrl;
   wire rd_data   = rd & hit_data;
   wire rd_stat   = rd & hit_stat;
   // Clear only what the read reported; a word or flag from its wait state or answer cycle survives
   wire rd_buf    = rd_data & rd_full_q;
   wire [3:0] stat_clr = rd_stat ? prdata_q[3:0] : 4'h0;

   // Link sampling, edges found on the bus clock
   usrx_sync #(
      .W (2)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({rx_clk, rx_data}),
      .q       (sync_o)
   );

   wire sclk_s    = sync_o[1];
   wire sd_s      = sync_o[0];
   wire sclk_rise = sclk_s & ~sclk_p_q;

   // Turnaround and enable
   wire tx_fall   = tx_prev_q & ~tx_enable;
   wire auto_set  = auto_q & tx_fall;
   // Hardware set beats a host clear in the same cycle
   assign rxen_d  = auto_set | (wr_ctrl ? pwdata[usrx_pkg::CTRL_RXEN] : rxen_q);
   wire clr       = ~rxen_d;

   usrx_rxshift u_shift (
      .pclk       (pclk),
      .presetn    (presetn),
      .clr        (clr),
      .sclk_rise  (sclk_rise),
      .sd         (sd_s),
      .word_q     (word),
      .word_vld_q (wv),
      .brk_q      (brk)
   );

   // Word disposition
   wire match     = (word == sync_q);
   wire data_ev   = wv & ~brk;
   wire strip     = data_ev & strip_q & match;
   wire keep      = data_ev & ~strip;
   wire load      = keep & ~full_q;
   wire ovr_ev    = keep & full_q;
   wire brk_ev    = wv & brk;
   wire brk_now   = brk_ev & ~full_q;
   wire brk_full  = brk_ev & full_q;
   wire post_brk  = rd_buf & brk_pend_q;
   wire post_ovr  = rd_buf & ovr_pend_q;

   wire [3:0] ev;
   assign ev[usrx_pkg::ST_FULL]  = load;
   assign ev[usrx_pkg::ST_OVR]   = post_ovr;
   assign ev[usrx_pkg::ST_BRK]   = brk_now | post_brk;
   assign ev[usrx_pkg::ST_MATCH] = load & match;

   // Read clears status, a new event in that cycle survives
   assign stat_d = clr ? usrx_pkg::STAT_RST
                       : ((stat_q & ~stat_clr) | ev);
   assign full_d = ~clr & (load | (full_q & ~rd_buf));

   wire [31:0] rdata_w =
      hit_ctrl ? {29'h0, auto_q, strip_q, rxen_q} :
      hit_sync ? {24'h0, sync_q} :
      hit_data ? {24'h0, buf_q} :
      hit_stat ? {27'h0, full_q, stat_q} :
      hit_mask ? {28'h0, mask_q} : 32'h0;

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxen_q  <= usrx_pkg::CTRL_RST[usrx_pkg::CTRL_RXEN];
         strip_q <= usrx_pkg::CTRL_RST[usrx_pkg::CTRL_STRIP];
         auto_q  <= usrx_pkg::CTRL_RST[usrx_pkg::CTRL_AUTO];
      end else begin
         rxen_q <= rxen_d;
         if (wr_ctrl) begin
            strip_q <= pwdata[usrx_pkg::CTRL_STRIP];
            auto_q  <= pwdata[usrx_pkg::CTRL_AUTO];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= usrx_pkg::SYNC_RST;
         mask_q <= usrx_pkg::MASK_RST;
      end else begin
         if (wr & hit_sync) sync_q <= pwdata[7:0];
         if (wr & hit_mask) mask_q <= pwdata[3:0];
      end
   end

   // Receive buffer and flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_q  <= 8'h00;
         full_q <= 1'b0;
         stat_q <= usrx_pkg::STAT_RST;
      end else begin
         if (load) buf_q <= word;
         full_q <= full_d;
         stat_q <= stat_d;
      end
   end

   // Pending conditions posted at the next buffer read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_pend_q <= 1'b0;
         brk_pend_q <= 1'b0;
      end else begin
         ovr_pend_q <= ~clr & (ovr_ev | (ovr_pend_q & ~rd_buf));
         brk_pend_q <= ~clr & (brk_full | (brk_pend_q & ~rd_buf));
      end
   end

   // Edge history, bus answer, interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_prev_q <= 1'b0;
         sclk_p_q  <= 1'b0;
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
         rd_full_q <= 1'b0;
      end else begin
         tx_prev_q <= tx_enable;
         sclk_p_q  <= sclk_s;
         pready_q  <= pready_d;
         prdata_q  <= (pready_d & ~pwrite) ? rdata_w : 32'h0;
         pslverr_q <= pready_d & ~hit_any;
         irq_q     <= |(stat_d & mask_q);
         rd_full_q <= pready_d & ~pwrite & hit_data & full_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_strip_drop: assert property (
      (strip & ~full_q & rxen_d) |=> !full_q && !stat_q[usrx_pkg::ST_FULL] ||
         $past(stat_q[usrx_pkg::ST_FULL] & ~stat_clr[usrx_pkg::ST_FULL]))
      else $error("matching word entered buffer with strip on");

   a_nostrip_load: assert property (
      (data_ev & ~strip_q & match & ~full_q & rxen_d) |=>
         full_q && buf_q == $past(word) && stat_q[usrx_pkg::ST_FULL])
      else $error("matching word not buffered with strip off");

   a_ctrl_follow: assert property (
      (wr_ctrl & ~auto_set) |=> rxen_q == $past(pwdata[0]) &&
         strip_q == $past(pwdata[1]) && auto_q == $past(pwdata[2]))
      else $error("control bits do not follow host write");

   a_off_clears: assert property (
      (wr_ctrl & ~pwdata[0] & ~auto_set) |=> !rxen_q && !full_q &&
         stat_q == 4'h0 && !ovr_pend_q && !brk_pend_q ##1 !wv)
      else $error("disable did not clear receiver at once");

   a_auto_turn: assert property (
      (auto_q & $fell(tx_enable)) |=> rxen_q)
      else $error("transmitter off did not re-enable receiver");

   a_brk_no_ovr: assert property (
      (brk_full & ~ovr_pend_q & ~rd_data & rxen_d) |=>
         brk_pend_q && !$rose(stat_q[usrx_pkg::ST_OVR]))
      else $error("break on full buffer raised overrun");

   a_brk_post: assert property (
      (post_brk & ~brk_full & rxen_d) |=> stat_q[usrx_pkg::ST_BRK] && !brk_pend_q)
      else $error("pending break not posted at buffer read");

   a_both_post: assert property (
      (post_brk & post_ovr & rxen_d) |=>
         stat_q[usrx_pkg::ST_BRK] && stat_q[usrx_pkg::ST_OVR])
      else $error("overrun and break not posted together");

   a_irq_level: assert property (
      $stable(mask_q) |-> irq_q == |(stat_q & mask_q))
      else $error("interrupt level disagrees with status and mask");

   a_apb_wait: assert property (
      pready_d |=> pready_q ##1 !pready_q)
      else $error("bus answer not one wait state");

   a_strip_keeps_buf: assert property (
      (strip & rxen_d) |=> buf_q == $past(buf_q))
      else $error("stripped word changed the buffer");

   a_match_flag: assert property (
      (load & match & rxen_d) |=> stat_q[usrx_pkg::ST_MATCH] && stat_q[usrx_pkg::ST_FULL])
      else $error("buffered sync character did not raise flags");

   a_hold_no_auto: assert property (
      (~auto_q & ~wr_ctrl) |=> rxen_q == $past(rxen_q))
      else $error("receiver enable moved without a host write");

   a_off_idle: assert property (
      clr |=> !wv && !full_q && stat_q == 4'h0 && !ovr_pend_q && !brk_pend_q)
      else $error("disabled receiver still holds a word or flag");

   a_brk_no_load: assert property (
      (brk_ev & rxen_d) |=> buf_q == $past(buf_q))
      else $error("break word entered the buffer");

   a_ovr_pended: assert property (
      (ovr_ev & ~rd_buf & rxen_d) |=> ovr_pend_q && !$rose(stat_q[usrx_pkg::ST_OVR]))
      else $error("overrun flagged before the buffer read");

   a_full_read: assert property (
      (rd_buf & rxen_d) |=> !full_q)
      else $error("buffer read left the buffer full");

   a_stat_set_wins: assert property (
      (rd_stat & ~clr & (|ev)) |=> (stat_q & $past(ev)) == $past(ev))
      else $error("status event lost to a read in the same cycle");

   a_prdata_idle: assert property (
      !pready_q |-> prdata_q == 32'h0)
      else $error("read data driven outside the answer cycle");

   c_strip:     cover property (strip & rxen_d);
   c_both_post: cover property (post_brk & post_ovr);
   c_auto_turn: cover property (auto_set & ~rxen_q);
   c_irq:       cover property ($rose(irq_q));
   c_brk_full:  cover property (brk_full & rxen_d);
endmodule : usrx_rx_ctrl

// ===== hdl/usrx_pkg.sv
package usrx_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;

   // Control field positions
   localparam int CTRL_RXEN  = 0;
   localparam int CTRL_STRIP = 1;
   localparam int CTRL_AUTO  = 2;

   // Status and mask field positions
   localparam int ST_FULL  = 0;
   localparam int ST_OVR   = 1;
   localparam int ST_BRK   = 2;
   localparam int ST_MATCH = 3;
   localparam int ST_LIVE  = 4;
   localparam int ST_W     = 4;

   // Values after reset
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] SYNC_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [3:0] STAT_RST = 4'h0;

   // Word framing
   localparam int         DATA_W   = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [1:0] {
      USRX_IDLE = 2'h0,
      USRX_DATA = 2'h1,
      USRX_STOP = 2'h3,
      USRX_BRKW = 2'h2
   } usrx_state_t;
endpackage : usrx_pkg

// ===== hdl/usrx_sync.sv
`timescale 1ns/1ps
module usrx_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input  logic         pclk,
   input  logic         presetn,
   // Asynchronous levels in, synchronised out
   input  logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q[i] <= 1'b0;
               q[i]      <= 1'b0;
            end else begin
               meta_q[i] <= d[i];
               q[i]      <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule : usrx_sync

// ===== hdl/usrx_rxshift.sv
`timescale 1ns/1ps
module usrx_rxshift (
   // Clock and reset
   input  logic                     pclk,
   input  logic                     presetn,
   // Control
   input  logic                     clr,
   // Sampled line
   input  logic                     sclk_rise,
   input  logic                     sd,
   // Assembled word
   output logic [usrx_pkg::DATA_W-1:0] word_q,
   output logic                     word_vld_q,
   output logic                     brk_q
);
   usrx_pkg::usrx_state_t         state_q;
   usrx_pkg::usrx_state_t         state_d;
   logic [2:0]                    cnt_q;
   logic [usrx_pkg::DATA_W-1:0]   sh_q;
   wire                           zero_word;
   wire                           brk_now;
   wire                           stop_hit;
   wire                           brk_end;

   assign zero_word = (sh_q == 8'h00);
   // Stop bit low on an all-zero word marks a break
   assign brk_now   = zero_word & ~sd;
   assign stop_hit  = sclk_rise & (state_q == usrx_pkg::USRX_STOP);
   // Link clock stops after a break, so the wait ends on the line level alone
   assign brk_end   = (state_q == usrx_pkg::USRX_BRKW) & sd;

   always_comb begin
      state_d = state_q;
      case (state_q)
         usrx_pkg::USRX_IDLE: if (!sd) state_d = usrx_pkg::USRX_DATA;
         usrx_pkg::USRX_DATA: if (cnt_q == usrx_pkg::BIT_LAST) state_d = usrx_pkg::USRX_STOP;
         usrx_pkg::USRX_STOP: state_d = brk_now ? usrx_pkg::USRX_BRKW : usrx_pkg::USRX_IDLE;
         usrx_pkg::USRX_BRKW: if (sd) state_d = usrx_pkg::USRX_IDLE;
         default:             state_d = usrx_pkg::USRX_IDLE;
      endcase
   end

   // A disable drops a half-built word at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= usrx_pkg::USRX_IDLE;
         cnt_q   <= 3'h0;
         sh_q    <= 8'h00;
      end else if (clr) begin
         state_q <= usrx_pkg::USRX_IDLE;
         cnt_q   <= 3'h0;
      end else if (brk_end) begin
         state_q <= usrx_pkg::USRX_IDLE;
      end else if (sclk_rise) begin
         state_q <= state_d;
         if (state_q == usrx_pkg::USRX_DATA) begin
            sh_q  <= {sd, sh_q[7:1]};
            cnt_q <= cnt_q + 3'h1;
         end else begin
            cnt_q <= 3'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q     <= 8'h00;
         word_vld_q <= 1'b0;
         brk_q      <= 1'b0;
      end else begin
         word_vld_q <= stop_hit & ~clr;
         if (stop_hit) begin
            word_q <= sh_q;
            brk_q  <= brk_now;
         end
      end
   end
endmodule : usrx_rxshift

// ===== tb/usrx_tx_model.sv
`timescale 1ns/1ps
module usrx_tx_model (
   // Link pins
   output logic rx_clk,
   output logic rx_data
);
   // Clock idles low and stands still between frames
   initial begin
      rx_clk  = 1'b0;
      rx_data = 1'b1;
   end

   // Start, eight data bits LSB first, stop; zero data with stop 0 is a break
   task automatic send(input logic [7:0] w, input logic stop);
      logic [9:0] f;
      // Offset keeps link edges off the bus clock edges
      #7;
      f = {stop, w, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_data = f[i];
         #160 rx_clk = 1'b1;
         #160 rx_clk = 1'b0;
      end
      // Released line returns to mark
      rx_data = 1'b1;
   endtask : send
endmodule : usrx_tx_model

// ===== tb/usrx_rx_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module usrx_rx_ctrl_test;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_clk;
   logic        rx_data;
   logic        tx_enable;
   logic        irq;
   logic [31:0] rdat;
   logic        rerr;
   int          n_fail;
   int          checked;

   usrx_rx_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_clk(rx_clk), .rx_data(rx_data), .tx_enable(tx_enable),
      .irq(irq));
   usrx_tx_model u_tx (.rx_clk(rx_clk), .rx_data(rx_data));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic complete_run;
      $display("Mismatches %0d, checks %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // One APB transfer; the wait is bounded so a silent slave ends the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         complete_run();
      end
   endtask : apb

   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rdat)
   endtask : chk_rd

   task automatic frame(input logic [7:0] w, input logic stop);
      u_tx.send(w, stop);
      // Word disposition lands a few cycles after the stop edge
      repeat (8) @(posedge pclk);
   endtask : frame

   initial begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      tx_enable = 1'b0;
      n_fail    = 0;
      checked   = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk_rd("ctrl rst", usrx_pkg::ADDR_CTRL, 32'h0);
      chk_rd("sync rst", usrx_pkg::ADDR_SYNC, 32'h0);
      chk_rd("mask rst", usrx_pkg::ADDR_MASK, 32'h0);
      chk_rd("stat rst", usrx_pkg::ADDR_STAT, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
      apb(1'b1, usrx_pkg::ADDR_SYNC, 32'h7E);
      apb(1'b1, usrx_pkg::ADDR_MASK, 32'hF);
      // Link clock idle and settled before the receiver is enabled
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h1);
      chk_rd("ctrl en", usrx_pkg::ADDR_CTRL, 32'h1);
      frame(8'h7E, 1'b1);
      `CHK("irq match", 1'b1, irq)
      chk_rd("stat match", usrx_pkg::ADDR_STAT, 32'h19);
      chk_rd("data match", usrx_pkg::ADDR_DATA, 32'h7E);
      `CHK("irq idle", 1'b0, irq)
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h3);
      chk_rd("ctrl strip", usrx_pkg::ADDR_CTRL, 32'h3);
      frame(8'h7E, 1'b1);
      chk_rd("stat strip", usrx_pkg::ADDR_STAT, 32'h0);
      frame(8'h55, 1'b1);
      chk_rd("stat other", usrx_pkg::ADDR_STAT, 32'h11);
      chk_rd("data other", usrx_pkg::ADDR_DATA, 32'h55);
      // Break into a full buffer
      frame(8'h12, 1'b1);
      frame(8'h00, 1'b0);
      chk_rd("stat brk full", usrx_pkg::ADDR_STAT, 32'h11);
      chk_rd("data brk", usrx_pkg::ADDR_DATA, 32'h12);
      chk_rd("stat brk post", usrx_pkg::ADDR_STAT, 32'h04);
      // Lost word, then break, before the read
      frame(8'h12, 1'b1);
      frame(8'h34, 1'b1);
      frame(8'h00, 1'b0);
      chk_rd("stat ovr full", usrx_pkg::ADDR_STAT, 32'h11);
      chk_rd("data ovr", usrx_pkg::ADDR_DATA, 32'h12);
      chk_rd("stat ovr post", usrx_pkg::ADDR_STAT, 32'h06);
      // Disable in mid-word drops the partial word
      fork
         u_tx.send(8'hFF, 1'b1);
      join_none
      repeat (30) @(posedge pclk);
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h2);
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h3);
      repeat (60) @(posedge pclk);
      chk_rd("stat cut", usrx_pkg::ADDR_STAT, 32'h0);
      // Disable with a word held and a flag raising irq
      frame(8'h56, 1'b1);
      `CHK("irq full", 1'b1, irq)
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK("irq off", 1'b0, irq)
      chk_rd("stat off", usrx_pkg::ADDR_STAT, 32'h0);
      chk_rd("ctrl off", usrx_pkg::ADDR_CTRL, 32'h0);
      // Transmitter drop without turnaround must not enable
      tx_enable <= 1'b1;
      @(posedge pclk);
      tx_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_rd("ctrl no auto", usrx_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, usrx_pkg::ADDR_CTRL, 32'h4);
      tx_enable <= 1'b1;
      @(posedge pclk);
      tx_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_rd("ctrl auto", usrx_pkg::ADDR_CTRL, 32'h5);
      frame(8'h21, 1'b1);
      chk_rd("data auto", usrx_pkg::ADDR_DATA, 32'h21);
      complete_run();
   end
endmodule : usrx_rx_ctrl_test
